// ===== inc/rrfu_pkg.sv
// shared types and constants of the rotate, round and flag unit
package rrfu_pkg;
   // ******************************************************************
   // widths and register numbering
   // ******************************************************************
   localparam int unsigned WORD_W = 32;
   localparam int unsigned EXT_W = 40;
   localparam int unsigned EXP_W = 8;
   localparam int unsigned DST_W = 5;
   localparam int unsigned NUM_REGS = 28;
   localparam logic [DST_W-1:0] EXT_REG_LAST = 5'h07; // extended_precision_regs 0..7
   // ******************************************************************
   // float layout and special values
   // ******************************************************************
   localparam int unsigned SIGN_POS = 31;
   localparam int unsigned DROP_W = 8;                  // mantissa bits dropped by rounding
   localparam logic [WORD_W-1:0] ROUND_HALF = 32'h0000_0080;
   localparam logic [WORD_W-1:0] KEEP_MASK = 32'hffff_ff00;
   localparam logic [EXP_W-1:0] EXP_ZERO = 8'h80;       // exponent of a zero value
   localparam logic [EXP_W-1:0] EXP_MAX = 8'h7f;
   localparam logic [WORD_W-1:0] MANT_MAX_POS = 32'h7fff_ff00;
   localparam logic [WORD_W-1:0] MANT_NEG_ONE = 32'h8000_0000;
   localparam logic [WORD_W-1:0] MANT_ZERO = 32'h0000_0000;
   // ******************************************************************
   // operations and flag carrier
   // ******************************************************************
   typedef enum logic [2:0] {
      OP_NONE,
      OP_ROTATE_LEFT,
      OP_ROTATE_LEFT_CARRY,
      OP_ROTATE_RIGHT,
      OP_ROTATE_RIGHT_CARRY,
      OP_ROUND_SINGLE
   } rrfu_op_t;

   typedef struct packed {
      logic latched_underflow_flag;
      logic latched_overflow_flag;
      logic underflow_flag;
      logic negative_flag;
      logic zero_flag;
      logic overflow_flag;
      logic carry_flag;
   } rrfu_flags_t;

   localparam rrfu_flags_t FLAGS_RESET = 7'h00;

   typedef struct packed {
      logic [EXT_W-1:0] value;
      logic underflow;
      logic overflow;
      logic zero_src;
   } rrfu_round_t;
endpackage

// ===== test/rrfu_seq_model.sv
// sequencer model that holds the status flags between operations
`timescale 1ns/100ps
`default_nettype none
module rrfu_seq_model
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // preset from the bench
   input wire logic load,
   input wire rrfu_pkg::rrfu_flags_t load_flags,
   // flag write from the unit
   input wire logic flags_we,
   input wire rrfu_pkg::rrfu_flags_t flags_out,
   // status flags fed back to the unit
   output var rrfu_pkg::rrfu_flags_t flags_in
);
   // status register, a bench preset wins over a unit write
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         flags_in <= rrfu_pkg::FLAGS_RESET;
      else if (load)
         flags_in <= load_flags;
      else if (flags_we)
         flags_in <= flags_out;
   end
endmodule
`default_nettype wire

// ===== test/rrfu_unit_sva.sv
// assertion checker for the rotate, round and flag unit
`timescale 1ns/100ps
`default_nettype none
module rrfu_unit_sva
#(
   parameter int unsigned NUM_REGS = 28
)
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // request
   input wire logic op_valid,
   input wire rrfu_pkg::rrfu_op_t op_code,
   input wire logic [rrfu_pkg::DST_W-1:0] dst_idx,
   input wire logic [rrfu_pkg::EXT_W-1:0] dst_val,
   input wire logic [rrfu_pkg::EXT_W-1:0] src_val,
   input wire rrfu_pkg::rrfu_flags_t flags_in,
   input wire logic overflow_mode_bit,
   // results
   input wire logic result_we,
   input wire logic [rrfu_pkg::DST_W-1:0] result_dst,
   input wire logic [rrfu_pkg::EXT_W-1:0] result_val,
   input wire logic flags_we,
   input wire rrfu_pkg::rrfu_flags_t flags_out,
   input wire logic op_error
);
   logic v_q;
   rrfu_pkg::rrfu_op_t op_q;
   logic [rrfu_pkg::DST_W-1:0] d_q;
   logic [rrfu_pkg::EXT_W-1:0] dv_q;
   logic [rrfu_pkg::EXT_W-1:0] sv_q;
   rrfu_pkg::rrfu_flags_t f_q;
   logic rot;
   logic low;
   logic rnd;
   // request taken at the previous edge
   always_ff @(posedge clock)
   begin
      v_q <= op_valid && !sys_rst;
      op_q <= op_code;
      d_q <= dst_idx;
      dv_q <= dst_val;
      sv_q <= src_val;
      f_q <= flags_in;
   end
   // kind of the answered request
   assign low = d_q <= rrfu_pkg::EXT_REG_LAST;
   assign rot = v_q && op_q >= rrfu_pkg::OP_ROTATE_LEFT
      && op_q <= rrfu_pkg::OP_ROTATE_RIGHT_CARRY && d_q < NUM_REGS;
   assign rnd = v_q && op_q == rrfu_pkg::OP_ROUND_SINGLE && low;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   property p_left;
      rot && op_q == rrfu_pkg::OP_ROTATE_LEFT |-> result_val[31:0] == {dv_q[30:0], dv_q[31]}
         && (!low || flags_out.carry_flag == dv_q[31]);
   endproperty
   a_left: assert property (p_left) else $error("left rotate wrong");
   property p_left_c;
      rot && op_q == rrfu_pkg::OP_ROTATE_LEFT_CARRY
         |-> result_val[31:0] == {dv_q[30:0], f_q.carry_flag}
         && (!low || flags_out.carry_flag == dv_q[31]);
   endproperty
   a_left_c: assert property (p_left_c) else $error("left carry rotate wrong");
   property p_right;
      rot && op_q == rrfu_pkg::OP_ROTATE_RIGHT |-> result_val[31:0] == {dv_q[0], dv_q[31:1]}
         && (!low || flags_out.carry_flag == dv_q[0]);
   endproperty
   a_right: assert property (p_right) else $error("right rotate wrong");
   property p_right_c;
      rot && op_q == rrfu_pkg::OP_ROTATE_RIGHT_CARRY
         |-> result_val[31:0] == {f_q.carry_flag, dv_q[31:1]}
         && (!low || flags_out.carry_flag == dv_q[0]);
   endproperty
   a_right_c: assert property (p_right_c) else $error("right carry rotate wrong");
   property p_gate;
      rot |-> result_we && result_dst == d_q && flags_we == low && !op_error
         && result_val[39:32] == dv_q[39:32];
   endproperty
   a_gate: assert property (p_gate) else $error("rotate write enables wrong");
   property p_rflags;
      rot && low |-> !flags_out.underflow_flag && !flags_out.overflow_flag
         && flags_out.negative_flag == result_val[31]
         && flags_out.zero_flag == (result_val[31:0] == 32'h0000_0000)
         && flags_out[6:5] == f_q[6:5];
   endproperty
   a_rflags: assert property (p_rflags) else $error("rotate flags wrong");
   property p_keep;
      rot && !low |-> flags_out == f_q;
   endproperty
   a_keep: assert property (p_keep) else $error("flags changed for upper register");
   property p_rzero;
      rnd |-> flags_we && flags_out.zero_flag == f_q.zero_flag;
   endproperty
   a_rzero: assert property (p_rzero) else $error("round touched zero flag");
   property p_rzsrc;
      rnd && sv_q[39:32] == rrfu_pkg::EXP_ZERO
         |-> flags_out.underflow_flag && result_val == 40'h80_0000_0000;
   endproperty
   a_rzsrc: assert property (p_rzsrc) else $error("zero source handling wrong");
   property p_pulse;
      flags_we && !op_valid |=> !flags_we && !result_we;
   endproperty
   a_pulse: assert property (p_pulse) else $error("write pulse too long");
   // main scenarios reached
   c_rot_low: cover property (rot && low);
   c_rot_high: cover property (rot && !low);
   c_rnd_ovf: cover property (rnd && flags_out.overflow_flag);
endmodule
bind rrfu_unit rrfu_unit_sva #(.NUM_REGS(NUM_REGS)) u_sva (.clock(clock), .sys_rst(sys_rst),
   .op_valid(op_valid), .op_code(op_code), .dst_idx(dst_idx), .dst_val(dst_val),
   .src_val(src_val), .flags_in(flags_in), .overflow_mode_bit(overflow_mode_bit),
   .result_we(result_we), .result_dst(result_dst), .result_val(result_val),
   .flags_we(flags_we), .flags_out(flags_out), .op_error(op_error));
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the rotate, round and flag unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   localparam rrfu_pkg::rrfu_op_t op_lrot = rrfu_pkg::OP_ROTATE_LEFT;
   localparam rrfu_pkg::rrfu_op_t op_lrotc = rrfu_pkg::OP_ROTATE_LEFT_CARRY;
   localparam rrfu_pkg::rrfu_op_t op_rrot = rrfu_pkg::OP_ROTATE_RIGHT;
   localparam rrfu_pkg::rrfu_op_t op_rrotc = rrfu_pkg::OP_ROTATE_RIGHT_CARRY;
   localparam rrfu_pkg::rrfu_op_t op_rnd = rrfu_pkg::OP_ROUND_SINGLE;
   localparam rrfu_pkg::rrfu_op_t op_none = rrfu_pkg::OP_NONE;
   localparam rrfu_pkg::rrfu_op_t op_bad = rrfu_pkg::rrfu_op_t'(3'h6);
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic op_valid = 1'b0;
   rrfu_pkg::rrfu_op_t op_code = rrfu_pkg::OP_NONE;
   logic [4:0] dst_idx = 5'h00;
   logic [39:0] dst_val = 40'h00;
   logic [39:0] src_val = 40'h00;
   logic mode = 1'b0;
   logic load = 1'b0;
   rrfu_pkg::rrfu_flags_t load_flags = 7'h00;
   rrfu_pkg::rrfu_flags_t flags_in;
   rrfu_pkg::rrfu_flags_t flags_out;
   logic result_we;
   logic [4:0] result_dst;
   logic [39:0] result_val;
   logic flags_we;
   logic op_error;
   int fail_count = 0;
   int checks = 0;
   // 25 MHz clock
   always #20 clock = ~clock;
   rrfu_unit DUT (.clock(clock), .sys_rst(sys_rst), .op_valid(op_valid), .op_code(op_code),
      .dst_idx(dst_idx), .dst_val(dst_val), .src_val(src_val), .flags_in(flags_in),
      .overflow_mode_bit(mode), .result_we(result_we), .result_dst(result_dst),
      .result_val(result_val), .flags_we(flags_we), .flags_out(flags_out), .op_error(op_error));
   rrfu_seq_model u_seq (.clock(clock), .sys_rst(sys_rst), .load(load), .load_flags(load_flags),
      .flags_we(flags_we), .flags_out(flags_out), .flags_in(flags_in));
   // ******************************************************************
   // shared tasks
   // ******************************************************************
   task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // preset flags, issue one request, judge the answer one cycle later
   task automatic run(input rrfu_pkg::rrfu_op_t op, input logic [4:0] d, input logic [39:0] v,
      input rrfu_pkg::rrfu_flags_t fi, input logic m, input logic [39:0] ev,
      input rrfu_pkg::rrfu_flags_t ef, input logic [2:0] ewe);
      @(negedge clock);
      load = 1'b1;
      load_flags = fi;
      @(negedge clock);
      load = 1'b0;
      op_valid = 1'b1;
      op_code = op;
      dst_idx = d;
      // the unused operand gets the inverse, so a swapped operand shows up
      dst_val = (op == op_rnd) ? ~v : v;
      src_val = (op == op_rnd) ? v : ~v;
      mode = m;
      @(negedge clock);
      op_valid = 1'b0;
      cmp({37'h0, result_we, flags_we, op_error}, {37'h0, ewe});
      if (ewe[2])
      begin
         cmp(result_val, ev);
         cmp({35'h0, result_dst}, {35'h0, d});
      end
      cmp({33'h0, flags_out}, {33'h0, ef});
   endtask
   task automatic conclude;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ******************************************************************
   // scenarios
   // ******************************************************************
   task automatic t_left;
      run(op_lrot, 5'h03, 40'h0080025cd4, 7'h00, 1'b0, 40'h000004b9a9, 7'h01, 3'h6);
      run(op_lrot, 5'h03, 40'h0080025cd4, 7'h7e, 1'b1, 40'h000004b9a9, 7'h61, 3'h6);
      run(op_lrot, 5'h00, 40'h0000000000, 7'h13, 1'b0, 40'h0000000000, 7'h04, 3'h6);
      run(op_lrot, 5'h1b, 40'h0080000000, 7'h00, 1'b0, 40'h0000000001, 7'h00, 3'h4);
      $display("test left rotate done");
   endtask
   task automatic t_left_c;
      run(op_lrotc, 5'h03, 40'h0000000420, 7'h01, 1'b0, 40'h0000000841, 7'h00, 3'h6);
      run(op_lrotc, 5'h03, 40'h0080004281, 7'h00, 1'b1, 40'h0000008502, 7'h01, 3'h6);
      run(op_lrotc, 5'h0c, 40'h0080000000, 7'h01, 1'b0, 40'h0000000001, 7'h01, 3'h4);
      $display("test left carry rotate done");
   endtask
   task automatic t_right;
      run(op_rrot, 5'h07, 40'h5a00000421, 7'h00, 1'b0, 40'h5a80000210, 7'h09, 3'h6);
      run(op_rrot, 5'h14, 40'h0000000001, 7'h00, 1'b0, 40'h0080000000, 7'h00, 3'h4);
      $display("test right rotate done");
   endtask
   task automatic t_right_c;
      run(op_rrotc, 5'h04, 40'h0080000081, 7'h08, 1'b1, 40'h0040000040, 7'h01, 3'h6);
      run(op_rrotc, 5'h09, 40'h0000000000, 7'h01, 1'b0, 40'h0080000000, 7'h01, 3'h4);
      $display("test right carry rotate done");
   endtask
   task automatic t_round;
      run(op_rnd, 5'h02, 40'h0733c16eef, 7'h22, 1'b0, 40'h0733c16f00, 7'h20, 3'h6);
      run(op_rnd, 5'h02, 40'h0733c16e80, 7'h00, 1'b0, 40'h0733c16f00, 7'h00, 3'h6);
      run(op_rnd, 5'h05, 40'h8012345678, 7'h04, 1'b0, 40'h8000000000, 7'h14, 3'h6);
      run(op_rnd, 5'h05, 40'h8012345678, 7'h00, 1'b0, 40'h8000000000, 7'h10, 3'h6);
      run(op_rnd, 5'h01, 40'h7f7fffffff, 7'h00, 1'b1, 40'h7f7fffff00, 7'h22, 3'h6);
      run(op_rnd, 5'h01, 40'h7f7fffffff, 7'h00, 1'b0, 40'h8000000000, 7'h22, 3'h6);
      run(op_rnd, 5'h03, 40'h81ffffffc0, 7'h00, 1'b0, 40'h8000000000, 7'h50, 3'h6);
      run(op_rnd, 5'h03, 40'h05ffffff90, 7'h00, 1'b0, 40'h0480000000, 7'h08, 3'h6);
      $display("test round done");
   endtask
   task automatic t_refuse;
      run(op_lrot, 5'h1c, 40'h0000000001, 7'h05, 1'b0, 40'h00, 7'h05, 3'h1);
      run(op_rnd, 5'h08, 40'h0733c16eef, 7'h05, 1'b0, 40'h00, 7'h05, 3'h1);
      run(op_none, 5'h03, 40'h0000000001, 7'h05, 1'b0, 40'h00, 7'h05, 3'h0);
      run(op_bad, 5'h03, 40'h0000000001, 7'h05, 1'b0, 40'h00, 7'h05, 3'h1);
      $display("test refusals done");
   endtask
   // reset in mid-run while a request is presented: reset wins, all outputs clear
   task automatic t_reset;
      @(negedge clock);
      sys_rst = 1'b1;
      op_valid = 1'b1;
      op_code = op_lrot;
      dst_idx = 5'h03;
      dst_val = 40'h0080025cd4;
      @(negedge clock);
      sys_rst = 1'b0;
      op_valid = 1'b0;
      cmp({37'h0, result_we, flags_we, op_error}, 40'h0);
      cmp(result_val, 40'h0);
      cmp({35'h0, result_dst}, 40'h0);
      cmp({33'h0, flags_out}, 40'h0);
      run(op_lrot, 5'h03, 40'h0080025cd4, 7'h00, 1'b0, 40'h000004b9a9, 7'h01, 3'h6);
      $display("test reset done");
   endtask
   // main sequence
   initial
   begin
      repeat (4) @(posedge clock);
      @(negedge clock);
      sys_rst = 1'b0;
      t_left();
      t_left_c();
      t_right();
      t_right_c();
      t_reset();
      t_round();
      t_refuse();
      conclude();
   end
   // hang guard
   initial
   begin
      repeat (2000) @(posedge clock);
      fail_count++;
      conclude();
   end
endmodule
`default_nettype wire

// ===== verilog/rrfu_round.sv
// round an extended float to the nearest single-precision value
`timescale 1ns/100ps
`default_nettype none
module rrfu_round
(
   // operand and mode
   input wire logic [rrfu_pkg::EXT_W-1:0] src_val,
   input wire logic overflow_mode_bit,
   // rounded result with its exception indications
   output rrfu_pkg::rrfu_round_t round_out
);
   logic [rrfu_pkg::EXP_W-1:0] exp_in;
   logic [rrfu_pkg::WORD_W-1:0] mant_in;
   logic [rrfu_pkg::WORD_W-1:0] mant_sum;

   assign exp_in = src_val[rrfu_pkg::EXT_W-1:rrfu_pkg::WORD_W];
   assign mant_in = src_val[rrfu_pkg::WORD_W-1:0];
   // half an lsb added before truncation, so ties go toward plus
   assign mant_sum = mant_in + rrfu_pkg::ROUND_HALF;

   // renormalise after a carry, detect overflow and underflow
   always_comb
   begin
      round_out.value = {exp_in, mant_sum & rrfu_pkg::KEEP_MASK};
      round_out.underflow = 1'b0;
      round_out.overflow = 1'b0;
      round_out.zero_src = (exp_in == rrfu_pkg::EXP_ZERO);
      if (round_out.zero_src)
      begin
         round_out.value = {rrfu_pkg::EXP_ZERO, rrfu_pkg::MANT_ZERO};
      end
      else if (!mant_in[rrfu_pkg::SIGN_POS] && mant_sum[rrfu_pkg::SIGN_POS])
      begin
         // positive mantissa carried into the sign: double the scale
         if (exp_in == rrfu_pkg::EXP_MAX)
         begin
            round_out.overflow = 1'b1;
            // saturation only in overflow mode
            round_out.value = overflow_mode_bit ?
               {rrfu_pkg::EXP_MAX, rrfu_pkg::MANT_MAX_POS} :
               {exp_in + 8'h01, rrfu_pkg::MANT_ZERO};
         end
         else
         begin
            round_out.value = {exp_in + 8'h01, rrfu_pkg::MANT_ZERO};
         end
      end
      else if (mant_in[rrfu_pkg::SIGN_POS] && !mant_sum[rrfu_pkg::SIGN_POS])
      begin
         // negative mantissa rounded to minus one: halve the scale
         if (exp_in == (rrfu_pkg::EXP_ZERO + 8'h01))
         begin
            round_out.underflow = 1'b1;
            round_out.value = {rrfu_pkg::EXP_ZERO, rrfu_pkg::MANT_ZERO};
         end
         else
         begin
            round_out.value = {exp_in - 8'h01, rrfu_pkg::MANT_NEG_ONE};
         end
      end
   end
endmodule
`default_nettype wire

// ===== verilog/rrfu_unit.sv
// rotate, round-to-single and condition flag execution unit
//
// Notes on behaviour
// - round-to-single sets the overflow flag on float overflow and clears it otherwise.
// - round-to-single never changes the zero flag, even for a zero source.
// - round-to-single result handling depends on the overflow mode bit.
// - round-to-single rounds to nearest single value, ties toward the more positive one.
// - round-to-single sets underflow on underflow or zero source, else clears it, and sets
//       the latched flags on underflow or overflow, else leaves them.
// - rotates update flags only for destinations 0 to 7.
// - a flag-updating rotate clears underflow and overflow, copies the msb to negative,
//       sets zero for a zero result and keeps the latched flags.
// - plain left rotate is circular, the old msb goes to bit 0 and to carry.
// - plain rotates load carry with the bit shifted out, only for destinations 0 to 7.
// - left rotate through carry loads old carry into bit 0 and old msb into carry.
// - left rotate through carry to another register still inserts carry but keeps it.
// - plain right rotate is circular, the old lsb goes to the msb and to carry.
// - right rotate through carry is a 33-bit rotation, carry into msb, lsb into carry.
// - right rotate through carry to another register still inserts carry but keeps it.
// - rotates ignore the overflow mode bit.
`timescale 1ns/100ps
`default_nettype none
module rrfu_unit
#(
   parameter int unsigned NUM_REGS = rrfu_pkg::NUM_REGS
)
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // operation request from the sequencer
   input wire logic op_valid,
   input wire rrfu_pkg::rrfu_op_t op_code,
   input wire logic [rrfu_pkg::DST_W-1:0] dst_idx,
   input wire logic [rrfu_pkg::EXT_W-1:0] dst_val,
   input wire logic [rrfu_pkg::EXT_W-1:0] src_val,
   input wire rrfu_pkg::rrfu_flags_t flags_in,
   input wire logic overflow_mode_bit,
   // result towards the register file
   output logic result_we,
   output logic [rrfu_pkg::DST_W-1:0] result_dst,
   output logic [rrfu_pkg::EXT_W-1:0] result_val,
   // flags towards the status register
   output logic flags_we,
   output rrfu_pkg::rrfu_flags_t flags_out,
   // request carried an unknown operation or register
   output logic op_error
);
   // ******************************************************************
   // state
   // ******************************************************************
   typedef struct packed {
      logic result_we;
      logic [rrfu_pkg::DST_W-1:0] result_dst;
      logic [rrfu_pkg::EXT_W-1:0] result_val;
      logic flags_we;
      rrfu_pkg::rrfu_flags_t flags;
      logic op_error;
   } rrfu_state_t;

   rrfu_state_t state_reg;
   rrfu_state_t state_next;
   rrfu_pkg::rrfu_round_t round_res;

   // true for a destination that updates the condition flags
   function automatic logic rrfu_flag_dst(input logic [rrfu_pkg::DST_W-1:0] idx);
      return idx <= rrfu_pkg::EXT_REG_LAST;
   endfunction

   // flag pattern common to all rotates
   function automatic rrfu_pkg::rrfu_flags_t rrfu_rot_flags(
      input rrfu_pkg::rrfu_flags_t old_flags,
      input logic [rrfu_pkg::WORD_W-1:0] res,
      input logic carry_out
   );
      rrfu_pkg::rrfu_flags_t f;
      f = old_flags;                              // latched flags kept
      f.underflow_flag = 1'b0;
      f.overflow_flag = 1'b0;
      f.negative_flag = res[rrfu_pkg::SIGN_POS];
      f.zero_flag = (res == rrfu_pkg::MANT_ZERO);
      f.carry_flag = carry_out;
      return f;
   endfunction

   // ******************************************************************
   // rounding datapath
   // ******************************************************************
   rrfu_round u_round
   (
      .src_val(src_val),
      .overflow_mode_bit(overflow_mode_bit),
      .round_out(round_res)
   );

   // ******************************************************************
   // next-state logic
   // ******************************************************************
   // one request is executed per cycle, result and flags appear next edge
   always_comb
   begin
      logic [rrfu_pkg::WORD_W-1:0] word;
      logic [rrfu_pkg::WORD_W-1:0] rot;
      logic carry_out;
      logic upd;
      word = dst_val[rrfu_pkg::WORD_W-1:0];
      rot = word;
      carry_out = flags_in.carry_flag;
      upd = rrfu_flag_dst(dst_idx);
      state_next = state_reg;
      state_next.result_we = 1'b0;
      state_next.flags_we = 1'b0;
      state_next.op_error = 1'b0;
      state_next.flags = flags_in;
      if (op_valid)
      begin
         state_next.result_dst = dst_idx;
         // rotate path never looks at the overflow mode bit
         unique case (op_code)
            rrfu_pkg::OP_ROTATE_LEFT:
            begin
               rot = {word[rrfu_pkg::WORD_W-2:0], word[rrfu_pkg::SIGN_POS]};
               carry_out = word[rrfu_pkg::SIGN_POS];
            end
            rrfu_pkg::OP_ROTATE_LEFT_CARRY:
            begin
               rot = {word[rrfu_pkg::WORD_W-2:0], flags_in.carry_flag};
               carry_out = word[rrfu_pkg::SIGN_POS];
            end
            rrfu_pkg::OP_ROTATE_RIGHT:
            begin
               rot = {word[0], word[rrfu_pkg::WORD_W-1:1]};
               carry_out = word[0];
            end
            rrfu_pkg::OP_ROTATE_RIGHT_CARRY:
            begin
               rot = {flags_in.carry_flag, word[rrfu_pkg::WORD_W-1:1]};
               carry_out = word[0];
            end
            default:
            begin
               rot = word;
               carry_out = flags_in.carry_flag;
            end
         endcase
         unique case (op_code)
            rrfu_pkg::OP_ROTATE_LEFT,
            rrfu_pkg::OP_ROTATE_LEFT_CARRY,
            rrfu_pkg::OP_ROTATE_RIGHT,
            rrfu_pkg::OP_ROTATE_RIGHT_CARRY:
            begin
               if (32'(dst_idx) < NUM_REGS)
               begin
                  state_next.result_we = 1'b1;
                  // upper exponent byte is carried through unchanged
                  state_next.result_val = {dst_val[rrfu_pkg::EXT_W-1:rrfu_pkg::WORD_W], rot};
                  state_next.flags_we = upd;
                  if (upd)
                  begin
                     state_next.flags = rrfu_rot_flags(flags_in, rot, carry_out);
                  end
               end
               else
               begin
                  state_next.op_error = 1'b1;
               end
            end
            rrfu_pkg::OP_ROUND_SINGLE:
            begin
               if (upd)
               begin
                  state_next.result_we = 1'b1;
                  state_next.result_val = round_res.value;
                  state_next.flags_we = 1'b1;
                  state_next.flags.overflow_flag = round_res.overflow;
                  state_next.flags.underflow_flag =
                     round_res.underflow | round_res.zero_src;
                  state_next.flags.latched_underflow_flag =
                     flags_in.latched_underflow_flag | round_res.underflow;
                  state_next.flags.latched_overflow_flag =
                     flags_in.latched_overflow_flag | round_res.overflow;
                  state_next.flags.negative_flag =
                     round_res.value[rrfu_pkg::SIGN_POS];
                  state_next.flags.zero_flag = flags_in.zero_flag;
                  state_next.flags.carry_flag = flags_in.carry_flag;
               end
               else
               begin
                  state_next.op_error = 1'b1;
               end
            end
            default:
            begin
               state_next.op_error = (op_code != rrfu_pkg::OP_NONE);
            end
         endcase
      end
   end

   // ******************************************************************
   // state register
   // ******************************************************************
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // outputs straight from the state register
   assign result_we = state_reg.result_we;
   assign result_dst = state_reg.result_dst;
   assign result_val = state_reg.result_val;
   assign flags_we = state_reg.flags_we;
   assign flags_out = state_reg.flags;
   assign op_error = state_reg.op_error;
endmodule
`default_nettype wire
